// *** rtl/pdc_top.sv ***
// Our own choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defines.svh"

module pdc_top #(
    parameter int          ADDR_W   = 20,
    parameter logic [18:0] SETTLE_0 = `PDC_SETTLE_STATES_0,
    parameter logic [18:0] SETTLE_1 = `PDC_SETTLE_STATES_1,
    parameter logic [18:0] SETTLE_2 = `PDC_SETTLE_STATES_2,
    parameter logic [18:0] SETTLE_3 = `PDC_SETTLE_STATES_3,
    parameter logic [18:0] SETTLE_4 = `PDC_SETTLE_STATES_4,
    parameter logic [18:0] SETTLE_5 = `PDC_SETTLE_STATES_5
) (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [ADDR_W-1:0]     haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic [31:0]                hrdata,
    output logic                       hreadyout,
    output logic                       hresp,
    input  wire logic                  sleep_req,
    input  wire logic                  irq_any,
    input  wire logic                  ext_irq,
    input  wire logic                  bus_cycle_end,
    input  wire logic                  hw_standby_n,
    input  wire logic                  osc_fast,
    output pdc_pkg::pdc_clk_ctrl_t     clk_ctrl,
    output pdc_pkg::pdc_bus_pin_ctrl_t bus_pins,
    output logic [2:0]                 master_clk_sel,
    output logic                       duty_adjust_on,
    output pdc_pkg::pdc_mode_t         mode
);
    import pdc_pkg::*;

    // ======================================================
    // state and helpers
    pdc_state_t                  s;
    pdc_state_t                  next_s;
    logic [`PDC_DIV_STAGES-1:0]  div_tick;
    logic [18:0]                 settle_len;
    logic                        settle_done;
    logic [ADDR_W-3:0]           idx;
    logic                        hit;
    logic [1:0]                  hit_sel;
    logic                        master_tick;
    logic                        hw_stby;
    logic                        alive;
    logic                        gated;

    localparam logic [1:0] SEL_SBY = 2'h0;
    localparam logic [1:0] SEL_SCK = 2'h1;
    localparam logic [1:0] SEL_HI  = 2'h2;
    localparam logic [1:0] SEL_LO  = 2'h3;

    // ======================================================
    // sub blocks
    pdc_clk_div #(
        .STAGES (`PDC_DIV_STAGES)
    ) u_div (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .div_tick  (div_tick),
        .div_level ()
    );

    pdc_settle_timer u_settle (
        .hclk    (hclk),
        .hresetn (hresetn),
        .start   (s.settle_start),
        .load    (settle_len),
        .busy    (),
        .done    (settle_done)
    );

    // ======================================================
    // settle length
    // settle length table
    always_comb begin
        unique case (s.sts)
            3'h0: settle_len = SETTLE_0;
            3'h1: settle_len = SETTLE_1;
            3'h2: settle_len = SETTLE_2;
            3'h3: settle_len = SETTLE_3;
            3'h4: settle_len = SETTLE_4;
            3'h5: settle_len = SETTLE_5;
            // reserved code waits the longest, the safe side
            3'h6: settle_len = SETTLE_5;
            3'h7: settle_len = `PDC_SETTLE_STATES_7;
        endcase
    end

    // ======================================================
    // address decode
    assign idx = haddr[ADDR_W-1:2];

    always_comb begin
        hit     = 1'b1;
        hit_sel = SEL_SBY;
        if (idx == (ADDR_W-2)'(`PDC_IDX_STANDBY_CONTROL)) begin
            hit_sel = SEL_SBY;
        end else if (idx == (ADDR_W-2)'(`PDC_IDX_SYSTEM_CLOCK_CONTROL)) begin
            hit_sel = SEL_SCK;
        end else if (idx == (ADDR_W-2)'(`PDC_IDX_HALT_HIGH)) begin
            hit_sel = SEL_HI;
        end else if (idx == (ADDR_W-2)'(`PDC_IDX_HALT_LOW)) begin
            hit_sel = SEL_LO;
        end else begin
            hit = 1'b0;
        end
    end

    // ======================================================
    // master clock pick
    // select divided or full clock
    always_comb begin
        unique case (s.act_sck)
            3'h1, 3'h2, 3'h3, 3'h4, 3'h5: master_tick = div_tick[s.act_sck - 3'h1];
            3'h0, 3'h6, 3'h7:             master_tick = 1'b1;
        endcase
    end

    assign hw_stby = s.hws[1];

    // ======================================================
    // next state
    always_comb begin
        next_s              = s;
        next_s.settle_start = 1'b0;
        // pin inputs pass two flops before use
        next_s.hws          = {s.hws[0], ~hw_standby_n};
        next_s.oscs         = {s.oscs[0], osc_fast};
        next_s.duty_on      = s.oscs[1];

        // data phase write; cpu is halted outside run
        // no writes while in standby
        if (s.dp_valid && s.dp_wr && s.mode == PDC_RUN) begin
            unique case (s.dp_sel)
                SEL_SBY: begin
                    next_s.deep_standby_select = hwdata[`PDC_SBY_SELECT_BIT];
                    next_s.sts  = hwdata[`PDC_SBY_STS_MSB:`PDC_SBY_STS_LSB];
                    next_s.bus_output_hold_enable  = hwdata[`PDC_SBY_OPE_BIT];
                end
                SEL_SCK: begin
                    next_s.sck_keep = hwdata[`PDC_SCK_KEEP_MSB:`PDC_SCK_KEEP_LSB];
                    next_s.sck      = hwdata[`PDC_SCK_SEL_MSB:0];
                end
                SEL_HI: next_s.mstp[15:8] = hwdata[7:0];
                SEL_LO: next_s.mstp[7:0]  = hwdata[7:0];
            endcase
        end

        // address phase capture
        next_s.dp_valid = hsel && htrans[1] && hready && hit && (hsize == `PDC_HSIZE_WORD);
        next_s.dp_wr    = hwrite;
        next_s.dp_sel   = hit_sel;

        // select applies at bus cycle end
        // halt bits apply at bus cycle end
        if (bus_cycle_end) begin
            next_s.act_sck  = s.sck;
            next_s.act_mstp = s.mstp;
        end

        // mode machine, independent of divide and halt
        unique case (s.mode)
            PDC_RUN: begin
                if (sleep_req) begin
                    next_s.mode = s.deep_standby_select ? PDC_SSTBY : PDC_SLEEP;
                end
            end
            PDC_SLEEP: begin
                if (irq_any) begin
                    next_s.mode = PDC_RUN;
                end
            end
            PDC_SSTBY: begin
                if (ext_irq) begin
                    next_s.mode         = PDC_SETTLE;
                    next_s.settle_start = 1'b1;
                end
            end
            PDC_SETTLE: begin
                if (settle_done) begin
                    next_s.mode = PDC_RUN;
                end
            end
        endcase

        if (hw_stby) begin
            next_s.mode         = PDC_RUN;
            next_s.deep_standby_select         = 1'(`PDC_RST_STANDBY_CONTROL >> `PDC_SBY_SELECT_BIT);
            next_s.sts          = 3'h0;
            next_s.bus_output_hold_enable          = 1'b1;
            next_s.sck_keep     = 2'h0;
            next_s.sck          = 3'(`PDC_RST_SYSTEM_CLOCK_CONTROL);
            next_s.mstp         = {`PDC_RST_HALT_HIGH, `PDC_RST_HALT_LOW};
            next_s.act_sck      = 3'h0;
            next_s.act_mstp     = {`PDC_RST_HALT_HIGH, `PDC_RST_HALT_LOW};
            next_s.settle_start = 1'b0;
        end

        // read data from the updated copy, so a read right after
        // a write returns the new value
        // unused bits read zero
        next_s.rdata = 32'h0;
        if (hsel && htrans[1] && hready && hit && !hwrite) begin
            unique case (hit_sel)
                SEL_SBY: next_s.rdata[7:0] = {next_s.deep_standby_select, next_s.sts, next_s.bus_output_hold_enable, 3'h0};
                SEL_SCK: next_s.rdata[7:0] = {next_s.sck_keep, 3'h0, next_s.sck};
                SEL_HI:  next_s.rdata[7:0] = next_s.mstp[15:8];
                SEL_LO:  next_s.rdata[7:0] = next_s.mstp[7:0];
            endcase
        end
    end

    // ======================================================
    // clock and pin controls, from next state
    always_comb begin
        alive = !hw_stby && (next_s.mode == PDC_RUN || next_s.mode == PDC_SLEEP);
        gated = next_s.mode == PDC_SSTBY || next_s.mode == PDC_SETTLE || hw_stby;
    end

    // ======================================================
    // registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s.mode          <= PDC_RUN;
            s.deep_standby_select          <= 1'b0;
            s.sts           <= 3'h0;
            s.bus_output_hold_enable           <= 1'b1;
            s.sck_keep      <= 2'h0;
            s.sck           <= 3'h0;
            s.mstp          <= {`PDC_RST_HALT_HIGH, `PDC_RST_HALT_LOW};
            s.act_sck       <= 3'h0;
            s.act_mstp      <= {`PDC_RST_HALT_HIGH, `PDC_RST_HALT_LOW};
            s.dp_valid      <= 1'b0;
            s.dp_wr         <= 1'b0;
            s.dp_sel        <= 2'h0;
            s.rdata         <= 32'h0;
            s.hws           <= 2'h0;
            s.oscs          <= 2'h0;
            s.duty_on       <= 1'b0;
            s.settle_start  <= 1'b0;
            s.clk.cpu_en    <= 1'b1;
            s.clk.master_en <= 1'b1;
            s.clk.osc_run   <= 1'b1;
            s.clk.module_en <= ~{`PDC_RST_HALT_HIGH, `PDC_RST_HALT_LOW};
            s.clk.module_rst <= `PDC_HALT_RESET_MASK;
            s.pins          <= '0;
        end else begin
            s.mode         <= next_s.mode;
            s.deep_standby_select         <= next_s.deep_standby_select;
            s.sts          <= next_s.sts;
            s.bus_output_hold_enable          <= next_s.bus_output_hold_enable;
            s.sck_keep     <= next_s.sck_keep;
            s.sck          <= next_s.sck;
            s.mstp         <= next_s.mstp;
            s.act_sck      <= next_s.act_sck;
            s.act_mstp     <= next_s.act_mstp;
            s.dp_valid     <= next_s.dp_valid;
            s.dp_wr        <= next_s.dp_wr;
            s.dp_sel       <= next_s.dp_sel;
            s.rdata        <= next_s.rdata;
            s.hws          <= next_s.hws;
            s.oscs         <= next_s.oscs;
            s.duty_on      <= next_s.duty_on;
            s.settle_start <= next_s.settle_start;
            // cpu and masters on divided tick
            // cpu halts in sleep, registers kept
            s.clk.cpu_en    <= !hw_stby && next_s.mode == PDC_RUN && master_tick;
            s.clk.master_en <= alive && master_tick;
            s.clk.osc_run   <= !hw_stby && next_s.mode != PDC_SSTBY;
            // halted modules lose their clock; those in the reset mask are also held in reset
            s.clk.module_en <= {16{alive}} & ~next_s.act_mstp;
            // serial and converter reset when halted
            s.clk.module_rst <= `PDC_HALT_RESET_MASK & (next_s.act_mstp | {16{gated}});
            // float or hold bus pins in standby
            s.pins.float_en <= hw_stby || (next_s.mode == PDC_SSTBY && !next_s.bus_output_hold_enable);
            s.pins.hold_en  <= !hw_stby && next_s.mode == PDC_SSTBY && next_s.bus_output_hold_enable;
        end
    end

    // ======================================================
    // outputs
    assign hrdata         = s.rdata;
    // zero wait state slave, always okay
    assign hreadyout      = 1'b1;
    assign hresp          = 1'b0;
    assign clk_ctrl       = s.clk;
    assign bus_pins       = s.pins;
    assign master_clk_sel = s.act_sck;
    assign duty_adjust_on = s.duty_on;
    assign mode           = s.mode;

endmodule
`default_nettype wire

// *** rtl/pdc_defines.svh ***
`ifndef PDC_DEFINES_SVH
`define PDC_DEFINES_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define PDC_IDX_STANDBY_CONTROL      18'h0ff38
`define PDC_IDX_SYSTEM_CLOCK_CONTROL 18'h0ff3a
`define PDC_IDX_HALT_HIGH            18'h0ff3c
`define PDC_IDX_HALT_LOW             18'h0ff3d

// ==========================================================
// reset values
`define PDC_RST_STANDBY_CONTROL      8'h08
`define PDC_RST_SYSTEM_CLOCK_CONTROL 8'h00
`define PDC_RST_HALT_HIGH            8'h3f
`define PDC_RST_HALT_LOW             8'hff

// ==========================================================
// field positions
`define PDC_SBY_SELECT_BIT 7
`define PDC_SBY_STS_MSB    6
`define PDC_SBY_STS_LSB    4
`define PDC_SBY_OPE_BIT    3
`define PDC_SCK_SEL_MSB    2
`define PDC_SCK_KEEP_MSB   7
`define PDC_SCK_KEEP_LSB   6

// ==========================================================
// settle lengths in system clock states
`define PDC_SETTLE_STATES_0 19'd8192
`define PDC_SETTLE_STATES_1 19'd16384
`define PDC_SETTLE_STATES_2 19'd32768
`define PDC_SETTLE_STATES_3 19'd65536
`define PDC_SETTLE_STATES_4 19'd131072
`define PDC_SETTLE_STATES_5 19'd262144
`define PDC_SETTLE_STATES_7 19'd16

// ==========================================================
// misc
`define PDC_DIV_STAGES       5
`define PDC_HALT_RESET_MASK  16'h02e0
`define PDC_HSIZE_WORD       3'h2

`endif

// *** rtl/pdc_pkg.sv ***
`include "pdc_defines.svh"

package pdc_pkg;

    // ======================================================
    // modes
    typedef enum logic [1:0] {
        PDC_RUN    = 2'b00,
        PDC_SLEEP  = 2'b01,
        PDC_SSTBY  = 2'b10,
        PDC_SETTLE = 2'b11
    } pdc_mode_t;

    // ======================================================
    // carriers
    typedef struct packed {
        logic        cpu_en;
        logic        master_en;
        logic        osc_run;
        logic [15:0] module_en;
        logic [15:0] module_rst;
    } pdc_clk_ctrl_t;

    typedef struct packed {
        logic float_en;
        logic hold_en;
    } pdc_bus_pin_ctrl_t;

    // ======================================================
    // module states
    typedef struct packed {
        logic [`PDC_DIV_STAGES-1:0] cnt;
        logic [`PDC_DIV_STAGES-1:0] level;
    } pdc_div_state_t;

    typedef struct packed {
        logic        busy;
        logic        done;
        logic [18:0] cnt;
    } pdc_timer_state_t;

    typedef struct packed {
        pdc_mode_t         mode;
        logic              deep_standby_select;
        logic [2:0]        sts;
        logic              bus_output_hold_enable;
        logic [1:0]        sck_keep;
        logic [2:0]        sck;
        logic [15:0]       mstp;
        logic [2:0]        act_sck;
        logic [15:0]       act_mstp;
        logic              dp_valid;
        logic              dp_wr;
        logic [1:0]        dp_sel;
        logic [31:0]       rdata;
        logic [1:0]        hws;
        logic [1:0]        oscs;
        logic              duty_on;
        logic              settle_start;
        pdc_clk_ctrl_t     clk;
        pdc_bus_pin_ctrl_t pins;
    } pdc_state_t;

endpackage

// *** rtl/pdc_clk_div.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defines.svh"

module pdc_clk_div #(
    parameter int STAGES = `PDC_DIV_STAGES
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    output logic [STAGES-1:0]      div_tick,
    output logic [STAGES-1:0]      div_level
);
    import pdc_pkg::*;

    pdc_div_state_t s;
    pdc_div_state_t next_s;

    always_comb begin
        next_s       = s;
        next_s.cnt   = s.cnt + 1'b1;
        next_s.level = next_s.cnt;
    end

    for (genvar k = 0; k < STAGES; k++) begin : g_tick
        assign div_tick[k] = &s.cnt[k:0];
    end

    assign div_level = s.level;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire

// *** rtl/pdc_settle_timer.sv ***
`timescale 1ns/1ps
`default_nettype none

module pdc_settle_timer (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        start,
    input  wire logic [18:0] load,
    output logic             busy,
    output logic             done
);
    import pdc_pkg::*;

    pdc_timer_state_t s;
    pdc_timer_state_t next_s;

    always_comb begin
        next_s      = s;
        next_s.done = 1'b0;
        if (start) begin
            next_s.busy = 1'b1;
            next_s.cnt  = load - 19'd1;
        end else if (s.busy) begin
            if (s.cnt == 19'd0) begin
                next_s.busy = 1'b0;
                next_s.done = 1'b1;
            end else begin
                next_s.cnt = s.cnt - 19'd1;
            end
        end
    end

    assign busy = s.busy;
    assign done = s.done;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
endmodule
`default_nettype wire

// *** verification/pdc_top_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module pdc_top_properties (
    input wire logic                   hclk,
    input wire logic                   hresetn,
    input wire logic                   sleep_req,
    input wire logic                   irq_any,
    input wire logic                   ext_irq,
    input wire logic                   bus_cycle_end,
    input wire logic                   hw_standby_n,
    input wire logic                   osc_fast,
    input wire pdc_pkg::pdc_clk_ctrl_t clk_ctrl,
    input wire logic [2:0]             master_clk_sel,
    input wire logic                   duty_adjust_on,
    input wire pdc_pkg::pdc_mode_t     mode
);
    import pdc_pkg::*;
    logic [3:0] hist;
    logic       ok;
    // ==========================================================
    // checks
    // the standby pin is synchronised, so judge only after it sat high a while
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hist <= 4'h0;
        end else begin
            hist <= {hist[2:0], hw_standby_n};
        end
    end
    assign ok = hw_standby_n & (&hist);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_sleep_enter: assert property (
        mode == PDC_RUN && sleep_req && ok |=> mode inside {PDC_SLEEP, PDC_SSTBY})
        else $error("sleep request ignored");
    a_sleep_wake: assert property (
        mode == PDC_SLEEP && irq_any && ok |=> mode == PDC_RUN)
        else $error("no wake from sleep");
    a_sleep_halts: assert property (
        mode == PDC_SLEEP |-> !clk_ctrl.cpu_en && clk_ctrl.osc_run)
        else $error("sleep clocks wrong");
    a_stby_halts: assert property (
        mode == PDC_SSTBY |-> !clk_ctrl.osc_run && !clk_ctrl.cpu_en
        && clk_ctrl.module_en == 16'h0) else $error("standby clocks running");
    a_stby_exit: assert property (
        mode == PDC_SSTBY && ext_irq && ok |=> (mode == PDC_SETTLE) [*8])
        else $error("settle wait too short");
    a_settle_gated: assert property (
        mode == PDC_SETTLE |-> !clk_ctrl.cpu_en && !clk_ctrl.master_en
        && clk_ctrl.module_en == 16'h0) else $error("clocks open in settle");
    a_sel_at_end: assert property (
        disable iff (!hresetn || !hw_standby_n)
        master_clk_sel != $past(master_clk_sel) |-> $past(bus_cycle_end))
        else $error("select changed mid bus cycle");
    a_duty_follows: assert property (
        $past(hresetn, 3) && $past(hresetn, 2) && $past(hresetn)
        |-> duty_adjust_on == $past(osc_fast, 3)) else $error("duty adjust wrong");
endmodule
bind pdc_top pdc_top_properties pdc_top_properties_inst (.hclk, .hresetn, .sleep_req,
    .irq_any, .ext_irq, .bus_cycle_end, .hw_standby_n, .osc_fast, .clk_ctrl,
    .master_clk_sel, .duty_adjust_on, .mode);
`default_nettype wire

// *** verification/pdc_cpu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module pdc_cpu_model (
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic sleep_cmd,
    input  wire logic irq_cmd,
    input  wire logic ext_cmd,
    output logic      sleep_req,
    output logic      irq_any,
    output logic      ext_irq,
    output logic      bus_cycle_end
);
    logic       prev;
    logic [1:0] phase;
    // ==========================================================
    // cpu side: a bus cycle ends every fourth clock
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {prev, sleep_req, irq_any, ext_irq, bus_cycle_end} <= 5'h00;
            phase <= 2'h0;
        end else begin
            prev <= sleep_cmd;
            sleep_req <= sleep_cmd & ~prev;
            irq_any <= irq_cmd;
            ext_irq <= ext_cmd;
            phase <= phase + 2'h1;
            bus_cycle_end <= (phase == 2'h3);
        end
    end
endmodule
`default_nettype wire

// *** verification/power_down_clock_mode_ctrl_test.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pdc_defines.svh"
module power_down_clock_mode_ctrl_test;
    import pdc_pkg::*;
    localparam logic [19:0] A_SBY = {`PDC_IDX_STANDBY_CONTROL, 2'b00};
    localparam logic [19:0] A_SCK = {`PDC_IDX_SYSTEM_CLOCK_CONTROL, 2'b00};
    localparam logic [19:0] A_MHI = {`PDC_IDX_HALT_HIGH, 2'b00};
    localparam logic [19:0] A_MLO = {`PDC_IDX_HALT_LOW, 2'b00};
    logic              hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic              hw_standby_n = 1'b1, osc_fast = 1'b0, sleep_cmd = 1'b0;
    logic              irq_cmd = 1'b0, ext_cmd = 1'b0;
    logic [19:0]       haddr = 20'h0;
    logic [1:0]        htrans = 2'h0;
    logic [2:0]        hsize = `PDC_HSIZE_WORD;
    logic [31:0]       hwdata = 32'h0, hrdata;
    logic              hreadyout, hresp, sleep_req, irq_any, ext_irq, bus_cycle_end;
    logic              duty_adjust_on;
    logic [2:0]        master_clk_sel;
    pdc_clk_ctrl_t     clk_ctrl;
    pdc_bus_pin_ctrl_t bus_pins;
    pdc_mode_t         mode;
    int                fail_count = 0, tests_run = 0, k;
    int                settle_len [8] = '{`PDC_SETTLE_STATES_0, 10, 12, 14, 16, 20, 20, 16};
    // ==========================================================
    // harness: short settle counts keep the run brief; code 0 keeps its real length
    pdc_top #(.SETTLE_1(19'd10), .SETTLE_2(19'd12), .SETTLE_3(19'd14),
        .SETTLE_4(19'd16), .SETTLE_5(19'd20)) pdc_top_inst (.hclk, .hresetn, .hsel,
        .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout,
        .hresp, .sleep_req, .irq_any, .ext_irq, .bus_cycle_end, .hw_standby_n, .osc_fast,
        .clk_ctrl, .bus_pins, .master_clk_sel, .duty_adjust_on, .mode);
    pdc_cpu_model pdc_cpu_model_inst (.hclk, .hresetn, .sleep_cmd, .irq_cmd, .ext_cmd,
        .sleep_req, .irq_any, .ext_irq, .bus_cycle_end);
    always #25 hclk = ~hclk;
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bail();
        fail_count++;
        test_done();
    endtask
    task automatic step_rdy();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (n >= 50) bail();
    endtask
    task automatic wait_mode(input pdc_mode_t m);
        int n;
        n = 0;
        while (mode !== m && n < 400) begin
            @(posedge hclk);
            n++;
        end
        if (n >= 400) bail();
    endtask
    task automatic xfer(input logic w, input logic [19:0] a, input logic [7:0] d,
                        output logic [31:0] r);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        step_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        step_rdy();
        r = hrdata;
    endtask
    task automatic wr(input logic [19:0] a, input logic [7:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [19:0] a, input logic [7:0] e);
        logic [31:0] r;
        xfer(1'b0, a, 8'h0, r);
        check(r, {24'h0, e});
        check({31'h0, hresp}, 32'h0);
    endtask
    initial begin
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        check({14'h0, mode, clk_ctrl.module_en}, 32'hc000);
        rd(A_SBY, 8'h08);
        rd(A_SCK, 8'h00);
        rd(A_MHI, 8'h3f);
        rd(A_MLO, 8'hff);
        wr(A_SBY, 8'hff);
        rd(A_SBY, 8'hf8);
        wr(A_SCK, 8'hff);
        rd(A_SCK, 8'hc7);
        osc_fast <= 1'b1;
        for (int c = 0; c < 6; c++) begin
            wr(A_SCK, 8'(c));
            repeat (8) @(posedge hclk);
            check({29'h0, master_clk_sel}, c);
            k = 0;
            repeat (64) begin
                @(posedge hclk);
                k += clk_ctrl.cpu_en + clk_ctrl.master_en;
            end
            check(k, 128 >> c);
        end
        check({31'h0, duty_adjust_on}, 32'h1);
        wr(A_MHI, 8'h00);
        wr(A_MLO, 8'h20);
        wr(A_SCK, 8'h02);
        wr(A_SBY, 8'h08);
        repeat (8) @(posedge hclk);
        check({clk_ctrl.module_en, clk_ctrl.module_rst}, 32'hffdf_0020);
        sleep_cmd <= 1'b1;
        wait_mode(PDC_SLEEP);
        check({clk_ctrl.cpu_en, clk_ctrl.osc_run, master_clk_sel}, 32'h0a);
        sleep_cmd <= 1'b0;
        irq_cmd <= 1'b1;
        wait_mode(PDC_RUN);
        irq_cmd <= 1'b0;
        wr(A_SCK, 8'h00);
        for (int s = 0; s < 8; s++) begin
            // external clock, so any settle code is usable
            wr(A_SBY, {1'b1, 3'(s), s[0], 3'h0});
            sleep_cmd <= 1'b1;
            wait_mode(PDC_SSTBY);
            check({30'h0, bus_pins}, {30'h0, ~s[0], s[0]});
            wr(A_MHI, 8'h55);
            rd(A_MHI, 8'h00);
            sleep_cmd <= 1'b0;
            ext_cmd <= 1'b1;
            wait_mode(PDC_SETTLE);
            k = 0;
            while (mode === PDC_SETTLE && k < 9000) begin
                @(posedge hclk);
                k++;
            end
            check(k, settle_len[s] + 2);
            ext_cmd <= 1'b0;
            rd(A_SBY, {1'b1, 3'(s), s[0], 3'h0});
        end
        rd(A_MLO, 8'h20);
        wr(A_MLO, 8'h00);
        hw_standby_n <= 1'b0;
        repeat (6) @(posedge hclk);
        check({31'h0, bus_pins.float_en}, 32'h1);
        hw_standby_n <= 1'b1;
        repeat (6) @(posedge hclk);
        rd(A_SBY, 8'h08);
        rd(A_MLO, 8'hff);
        test_done();
    end
endmodule
`default_nettype wire
